/* hw/ppc_pkg.sv */
// shared constants and types for the phy port control and diagnostic register slice
package ppc_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [5:0] IDX_P1_DIAG   = 6'h1A;
    localparam logic [5:0] IDX_P1_FAULT  = 6'h1B;
    localparam logic [5:0] IDX_P1_LINK   = 6'h1C;
    localparam logic [5:0] IDX_P2_DIAG   = 6'h2A;
    localparam logic [5:0] IDX_P2_FAULT  = 6'h2B;
    localparam logic [5:0] IDX_P2_LINK   = 6'h2C;
    localparam int         NUM_PORTS     = 2;
    localparam int         ADDR_W        = 8;
    localparam int         DATA_W        = 32;

    // ==========================================================
    // diagnostic and loopback control field positions
    localparam int BIT_CT_EN      = 4;
    localparam int BIT_LINK_PASS  = 3;
    localparam int BIT_DIAG_RSVD  = 2;
    localparam int BIT_RLOOP      = 1;
    localparam int BIT_FAULT_MSB  = 0;

    // link control field positions
    localparam int BIT_AUTONEG    = 7;
    localparam int BIT_SPEED_100  = 6;
    localparam int BIT_FULL_DUP   = 5;

    // ==========================================================
    // values after reset
    localparam logic       RST_CT_EN     = 1'b0;
    localparam logic       RST_LINK_PASS = 1'b0;
    localparam logic       RST_RLOOP     = 1'b0;
    localparam logic       RST_FULL_DUP  = 1'b1;
    localparam logic       RST_DIAG_RSVD = 1'b0;
    localparam logic [8:0] RST_FAULT     = 9'h000;

    // ==========================================================
    // diagnostic engine
    localparam int         FAULT_W        = 9;
    localparam logic [8:0] FAULT_MAX      = 9'h1FF;
    localparam int         PRE_W          = 16;
    localparam int         STEP_CYCLES_DF = 1;
    localparam int         SYM_W_DF       = 5;

    typedef enum logic {
        TDR_IDLE,
        TDR_RUN
    } ppc_tdr_state_t;

    // ==========================================================
    // per-port control bundle toward the phy
    typedef struct packed {
        logic autoneg_en;
        logic speed_100;
        logic full_duplex;
        logic use_forced;
        logic link_pass;
        logic remote_loop;
    } ppc_phy_ctl_t;

    localparam ppc_phy_ctl_t RST_PHY_CTL = '{
        autoneg_en:  1'b1,
        speed_100:   1'b1,
        full_duplex: 1'b1,
        use_forced:  1'b0,
        link_pass:   1'b0,
        remote_loop: 1'b0
    };

endpackage

/* hw/ppc_tdr_engine.sv */
// cable diagnostic run sequencer with held fault count
`timescale 1ns/10ps
module ppc_tdr_engine #(
    parameter int STEP_CYCLES = ppc_pkg::STEP_CYCLES_DF
) (
    input  wire logic                   mclk,
    input  wire logic                   sys_rst,
    input  wire logic                   ce,
    input  wire logic                   start,
    input  wire logic                   echo,
    output logic                        done,
    output logic [ppc_pkg::FAULT_W-1:0] fault_cnt
);

    // ==========================================================
    // state
    ppc_pkg::ppc_tdr_state_t          st_r;
    ppc_pkg::ppc_tdr_state_t          st_nxt;
    logic [ppc_pkg::FAULT_W-1:0]      cnt_r;
    logic [ppc_pkg::FAULT_W-1:0]      cnt_nxt;
    logic [ppc_pkg::PRE_W-1:0]        pre_r;
    logic [ppc_pkg::PRE_W-1:0]        pre_nxt;
    logic                             done_r;
    logic                             done_nxt;

    localparam logic [ppc_pkg::PRE_W-1:0] PRE_LAST = ppc_pkg::PRE_W'(STEP_CYCLES - 1);

    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        pre_nxt  = pre_r;
        done_nxt = 1'b0;
        case (st_r)
            ppc_pkg::TDR_IDLE: begin
                pre_nxt = '0;
            end
            ppc_pkg::TDR_RUN: begin
                // echo ends the run; no echo by full scale means no fault in range
                if (echo) begin
                    st_nxt   = ppc_pkg::TDR_IDLE;
                    done_nxt = 1'b1;
                end else if (pre_r == PRE_LAST) begin
                    pre_nxt = '0;
                    if (cnt_r == ppc_pkg::FAULT_MAX) begin
                        st_nxt   = ppc_pkg::TDR_IDLE;
                        done_nxt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 9'h001;
                    end
                end else begin
                    pre_nxt = pre_r + 16'h0001;
                end
            end
            default: begin
                st_nxt = ppc_pkg::TDR_IDLE;
            end
        endcase
        // count held until a new run starts
        if (start) begin
            st_nxt   = ppc_pkg::TDR_RUN;
            cnt_nxt  = ppc_pkg::RST_FAULT; // R14
            pre_nxt  = '0;
            done_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r   <= ppc_pkg::TDR_IDLE;
            cnt_r  <= ppc_pkg::RST_FAULT;
            pre_r  <= '0;
            done_r <= 1'b0;
        end else if (ce) begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            pre_r  <= pre_nxt;
            done_r <= done_nxt;
        end
    end

    assign done      = done_r;
    assign fault_cnt = cnt_r;

endmodule

/* hw/ppc_loop_path.sv */
// per-port symbol path with remote loopback at the pmd/pma layer
`timescale 1ns/10ps
module ppc_loop_path #(
    parameter int SYM_W = ppc_pkg::SYM_W_DF
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    input  wire logic             loop_en,
    input  wire logic [SYM_W-1:0] rx_sym,
    input  wire logic [SYM_W-1:0] mac_tx_sym,
    output logic      [SYM_W-1:0] tx_sym,
    output logic      [SYM_W-1:0] mac_rx_sym
);

    logic [SYM_W-1:0] tx_r;
    logic [SYM_W-1:0] tx_nxt;
    logic [SYM_W-1:0] mrx_r;
    logic [SYM_W-1:0] mrx_nxt;

    always_comb begin
        // loop turns inside this port's phy, never through the switch
        tx_nxt  = loop_en ? rx_sym : mac_tx_sym; // R6 R7
        mrx_nxt = rx_sym;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tx_r  <= '0;
            mrx_r <= '0;
        end else if (ce) begin
            tx_r  <= tx_nxt;
            mrx_r <= mrx_nxt;
        end
    end

    assign tx_sym     = tx_r;
    assign mac_rx_sym = mrx_r;

endmodule

/* hw/ppc_regs.sv */
// apb register slice for phy port control, cable diagnostic and remote loopback
// Notes on behaviour
// R1: writing one to cable test enable starts a run; hardware clears it when done
// R2: software reads enable zero as run complete and result valid
// R3: nine-bit read-only fault count, top bit at bit 0 of control register
// R4: low eight bits of fault count in own read-only register, reset zero
// R5: fault distance is about 0.4 metre times the fault count
// R6: remote loopback sends received port data back out the same port
// R7: loopback point is the port phy pmd/pma; bit zero means normal operation
// R8: bit 2 of diagnostic control is reserved, read-only, reads zero
// R9: autoneg bit 7 set negotiates; cleared uses forced speed and duplex bits
// R10: force speed one selects 100BT, zero selects 10BT when autoneg off
// R11: autoneg enable reset value taken from per-port strap pin during reset
// R12: force speed reset value taken from per-port strap pin during reset
// R13: bit 5 forces full or half duplex when autoneg off or failed
// R14: fault count from last run holds until next run or reset
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module ppc_regs #(
    parameter int STEP_CYCLES = ppc_pkg::STEP_CYCLES_DF,
    parameter int SYM_W       = ppc_pkg::SYM_W_DF
) (
    input  wire logic                          mclk,
    input  wire logic                          sys_rst,
    input  wire logic                          ce,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ppc_pkg::ADDR_W-1:0]    paddr,
    input  wire logic [ppc_pkg::DATA_W-1:0]    pwdata,
    output logic      [ppc_pkg::DATA_W-1:0]    prdata,
    output logic                               pready,
    output logic                               pslverr,
    // strap pins
    input  wire logic                          port1_strap_a,
    input  wire logic                          port1_strap_b,
    input  wire logic                          port2_strap_a,
    input  wire logic                          port2_strap_b,
    // cable reflection detect from the analog front end
    input  wire logic                          port1_echo,
    input  wire logic                          port2_echo,
    // autoneg failure flags from phy logic
    input  wire logic [ppc_pkg::NUM_PORTS-1:0] autoneg_failed,
    // symbol paths
    input  wire logic [SYM_W-1:0]              port1_rx_pair,
    input  wire logic [SYM_W-1:0]              port2_rx_pair,
    input  wire logic [SYM_W-1:0]              port1_mac_tx,
    input  wire logic [SYM_W-1:0]              port2_mac_tx,
    output logic      [SYM_W-1:0]              port1_tx_pair,
    output logic      [SYM_W-1:0]              port2_tx_pair,
    output logic      [SYM_W-1:0]              port1_mac_rx,
    output logic      [SYM_W-1:0]              port2_mac_rx,
    // control toward each phy
    output ppc_pkg::ppc_phy_ctl_t              port1_phy_ctl,
    output ppc_pkg::ppc_phy_ctl_t              port2_phy_ctl
);

    localparam int NP = ppc_pkg::NUM_PORTS;

    // ==========================================================
    // pin synchronisers
    logic [NP-1:0] strap_a_s1_r;
    logic [NP-1:0] strap_a_s2_r;
    logic [NP-1:0] strap_b_s1_r;
    logic [NP-1:0] strap_b_s2_r;
    logic [NP-1:0] echo_s1_r;
    logic [NP-1:0] echo_s2_r;

    always_ff @(posedge mclk) begin
        if (ce) begin
            strap_a_s1_r <= {port2_strap_a, port1_strap_a};
            strap_a_s2_r <= strap_a_s1_r;
            strap_b_s1_r <= {port2_strap_b, port1_strap_b};
            strap_b_s2_r <= strap_b_s1_r;
            echo_s1_r    <= {port2_echo, port1_echo};
            echo_s2_r    <= echo_s1_r;
        end
    end

    // ==========================================================
    // apb access decode
    logic                        setup_ph;
    logic                        wr_acc;
    logic                        pready_r;
    logic                        pready_nxt;
    logic                        pslverr_r;
    logic                        pslverr_nxt;
    logic [ppc_pkg::DATA_W-1:0]  prdata_r;
    logic [ppc_pkg::DATA_W-1:0]  prdata_nxt;
    logic [5:0]                  idx;
    logic                        aligned;

    assign setup_ph = psel & ~penable;
    assign wr_acc   = psel & penable & pready_r & pwrite & ~pslverr_r;
    assign idx      = paddr[7:2];
    assign aligned  = (paddr[1:0] == 2'b00);

    // ==========================================================
    // per-port state shared with the read mux
    logic [NP-1:0]               ct_en_w;
    logic [NP-1:0]               link_pass_w;
    logic [NP-1:0]               rloop_w;
    logic [NP-1:0]               an_w;
    logic [NP-1:0]               spd_w;
    logic [NP-1:0]               dup_w;
    logic [ppc_pkg::FAULT_W-1:0] fault_w   [NP];
    logic [SYM_W-1:0]            rx_w      [NP];
    logic [SYM_W-1:0]            mtx_w     [NP];
    logic [SYM_W-1:0]            tx_w      [NP];
    logic [SYM_W-1:0]            mrx_w     [NP];
    ppc_pkg::ppc_phy_ctl_t       phy_ctl_w [NP];

    assign rx_w[0]  = port1_rx_pair;
    assign rx_w[1]  = port2_rx_pair;
    assign mtx_w[0] = port1_mac_tx;
    assign mtx_w[1] = port2_mac_tx;

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            localparam logic [5:0] I_DIAG = (p == 0) ? ppc_pkg::IDX_P1_DIAG
                                                     : ppc_pkg::IDX_P2_DIAG;
            localparam logic [5:0] I_LINK = (p == 0) ? ppc_pkg::IDX_P1_LINK
                                                     : ppc_pkg::IDX_P2_LINK;

            logic                  wr_diag;
            logic                  wr_link;
            logic                  start;
            logic                  done;
            logic                  ct_en_r;
            logic                  ct_en_nxt;
            logic                  lp_r;
            logic                  lp_nxt;
            logic                  rl_r;
            logic                  rl_nxt;
            logic                  an_r;
            logic                  an_nxt;
            logic                  spd_r;
            logic                  spd_nxt;
            logic                  dup_r;
            logic                  dup_nxt;
            ppc_pkg::ppc_phy_ctl_t ctl_r;
            ppc_pkg::ppc_phy_ctl_t ctl_nxt;

            assign wr_diag = wr_acc & aligned & (idx == I_DIAG);
            assign wr_link = wr_acc & aligned & (idx == I_LINK);
            // start allowed while idle or in the finishing cycle
            assign start   = wr_diag & pwdata[ppc_pkg::BIT_CT_EN] & (~ct_en_r | done); // R1

            always_comb begin
                ct_en_nxt = ct_en_r;
                lp_nxt    = lp_r;
                rl_nxt    = rl_r;
                an_nxt    = an_r;
                spd_nxt   = spd_r;
                dup_nxt   = dup_r;
                // set wins over the self-clear
                if (done) begin
                    ct_en_nxt = 1'b0; // R1
                end
                if (start) begin
                    ct_en_nxt = 1'b1; // R1
                end
                if (wr_diag) begin
                    lp_nxt = pwdata[ppc_pkg::BIT_LINK_PASS];
                    rl_nxt = pwdata[ppc_pkg::BIT_RLOOP]; // R6
                end
                if (wr_link) begin
                    an_nxt  = pwdata[ppc_pkg::BIT_AUTONEG];
                    spd_nxt = pwdata[ppc_pkg::BIT_SPEED_100];
                    dup_nxt = pwdata[ppc_pkg::BIT_FULL_DUP];
                end
                ctl_nxt.autoneg_en  = an_r; // R9
                ctl_nxt.speed_100   = spd_r; // R10
                ctl_nxt.full_duplex = dup_r;
                ctl_nxt.use_forced  = ~an_r | autoneg_failed[p]; // R9 R13
                ctl_nxt.link_pass   = lp_r;
                ctl_nxt.remote_loop = rl_r; // R7
            end

            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    ct_en_r <= ppc_pkg::RST_CT_EN;
                    lp_r    <= ppc_pkg::RST_LINK_PASS;
                    rl_r    <= ppc_pkg::RST_RLOOP;
                    an_r    <= strap_a_s2_r[p]; // R11
                    spd_r   <= strap_b_s2_r[p]; // R12
                    dup_r   <= ppc_pkg::RST_FULL_DUP;
                    ctl_r   <= ppc_pkg::RST_PHY_CTL;
                end else if (ce) begin
                    ct_en_r <= ct_en_nxt;
                    lp_r    <= lp_nxt;
                    rl_r    <= rl_nxt;
                    an_r    <= an_nxt;
                    spd_r   <= spd_nxt;
                    dup_r   <= dup_nxt;
                    ctl_r   <= ctl_nxt;
                end
            end

            ppc_tdr_engine #(
                .STEP_CYCLES (STEP_CYCLES)
            ) u_tdr (
                .mclk      (mclk),
                .sys_rst   (sys_rst),
                .ce        (ce),
                .start     (start),
                .echo      (echo_s2_r[p]),
                .done      (done),
                .fault_cnt (fault_w[p])
            );

            ppc_loop_path #(
                .SYM_W (SYM_W)
            ) u_loop (
                .mclk       (mclk),
                .sys_rst    (sys_rst),
                .ce         (ce),
                .loop_en    (rl_r),
                .rx_sym     (rx_w[p]),
                .mac_tx_sym (mtx_w[p]),
                .tx_sym     (tx_w[p]),
                .mac_rx_sym (mrx_w[p])
            );

            assign ct_en_w[p]     = ct_en_r;
            assign link_pass_w[p] = lp_r;
            assign rloop_w[p]     = rl_r;
            assign an_w[p]        = an_r;
            assign spd_w[p]       = spd_r;
            assign dup_w[p]       = dup_r;
            assign phy_ctl_w[p]   = ctl_r;
        end
    endgenerate

    // ==========================================================
    // read mux
    logic [7:0] rd_byte;
    logic       hit;

    always_comb begin
        rd_byte = 8'h00;
        hit     = 1'b0;
        if (aligned) begin
            for (int i = 0; i < NP; i++) begin
                if (idx == ((i == 0) ? ppc_pkg::IDX_P1_DIAG : ppc_pkg::IDX_P2_DIAG)) begin
                    hit                             = 1'b1;
                    rd_byte[ppc_pkg::BIT_CT_EN]     = ct_en_w[i]; // R1
                    rd_byte[ppc_pkg::BIT_LINK_PASS] = link_pass_w[i];
                    rd_byte[ppc_pkg::BIT_DIAG_RSVD] = ppc_pkg::RST_DIAG_RSVD; // R8
                    rd_byte[ppc_pkg::BIT_RLOOP]     = rloop_w[i];
                    rd_byte[ppc_pkg::BIT_FAULT_MSB] = fault_w[i][8]; // R3
                end
                if (idx == ((i == 0) ? ppc_pkg::IDX_P1_FAULT : ppc_pkg::IDX_P2_FAULT)) begin
                    hit     = 1'b1;
                    rd_byte = fault_w[i][7:0]; // R4
                end
                if (idx == ((i == 0) ? ppc_pkg::IDX_P1_LINK : ppc_pkg::IDX_P2_LINK)) begin
                    hit                             = 1'b1;
                    rd_byte[ppc_pkg::BIT_AUTONEG]   = an_w[i];
                    rd_byte[ppc_pkg::BIT_SPEED_100] = spd_w[i];
                    rd_byte[ppc_pkg::BIT_FULL_DUP]  = dup_w[i];
                end
            end
        end
    end

    // ==========================================================
    // apb answer: one wait-free access phase
    always_comb begin
        pready_nxt  = setup_ph;
        pslverr_nxt = setup_ph & ~hit;
        prdata_nxt  = prdata_r;
        if (setup_ph) begin
            prdata_nxt = (hit & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else if (ce) begin
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign prdata        = prdata_r;
    assign port1_tx_pair = tx_w[0];
    assign port2_tx_pair = tx_w[1];
    assign port1_mac_rx  = mrx_w[0];
    assign port2_mac_rx  = mrx_w[1];
    assign port1_phy_ctl = phy_ctl_w[0];
    assign port2_phy_ctl = phy_ctl_w[1];

endmodule

/* verif/ppc_regs_properties.sv */
// bound assertions on the register slice ports
`timescale 1ns/10ps
module ppc_regs_chk #(
    parameter int SYM_W = 5
) (
    input wire logic                       mclk,
    input wire logic                       sys_rst,
    input wire logic                       ce,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic [ppc_pkg::ADDR_W-1:0] paddr,
    input wire logic [ppc_pkg::DATA_W-1:0] prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic [SYM_W-1:0]           port1_rx_pair,
    input wire logic [SYM_W-1:0]           port1_mac_tx,
    input wire logic [SYM_W-1:0]           port1_tx_pair,
    input wire logic [SYM_W-1:0]           port1_mac_rx,
    input wire ppc_pkg::ppc_phy_ctl_t      port1_phy_ctl,
    input wire ppc_pkg::ppc_phy_ctl_t      port2_phy_ctl
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // bus answer
    chk_ready_after_setup: assert property (psel && !penable && ce |=> pready)
        else $error("no ready");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready long");
    chk_err_unaligned: assert property (psel && !penable && ce && paddr[1:0] != 2'h0
        |=> pslverr && prdata == 32'h0000_0000) else $error("unaligned ok");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("err no ready");
    chk_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("high bits");

    // ==========================================================
    // symbol paths and forced mode
    chk_loop_on_path: assert property (!$past(sys_rst) && ce && port1_phy_ctl.remote_loop &&
        $past(port1_phy_ctl.remote_loop) |-> port1_tx_pair == $past(port1_rx_pair))
        else $error("loop on");
    chk_loop_off_path: assert property (!$past(sys_rst) && ce && !port1_phy_ctl.remote_loop &&
        !$past(port1_phy_ctl.remote_loop) |-> port1_tx_pair == $past(port1_mac_tx))
        else $error("loop off");
    chk_mac_rx_path: assert property (ce ##1 ce && !$past(sys_rst)
        |-> port1_mac_rx == $past(port1_rx_pair)) else $error("rx path");
    chk_forced_p1: assert property (!port1_phy_ctl.autoneg_en |-> port1_phy_ctl.use_forced)
        else $error("p1 forced");
    chk_forced_p2: assert property (!port2_phy_ctl.autoneg_en |-> port2_phy_ctl.use_forced)
        else $error("p2 forced");
endmodule

bind ppc_regs ppc_regs_chk #(.SYM_W(SYM_W)) u_chk (
    .mclk, .sys_rst, .ce, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
    .port1_rx_pair, .port1_mac_tx, .port1_tx_pair, .port1_mac_rx,
    .port1_phy_ctl, .port2_phy_ctl
);

/* verif/ppc_cable_model.sv */
// far-end cable model: changing rx symbols and a delayed reflection
`timescale 1ns/10ps
module ppc_cable_model #(
    parameter int SYM_W = 5
) (
    input  wire logic             mclk,
    input  wire logic             arm,
    input  wire logic [8:0]       dly,
    output logic                  echo,
    output logic      [SYM_W-1:0] rx_sym
);
    logic [8:0] left_r;

    initial begin
        left_r = 9'h000;
        echo = 1'b0;
        rx_sym = '0;
    end

    always @(posedge mclk) begin
        rx_sym <= rx_sym + SYM_W'(7);
        if (!arm) begin
            left_r <= dly;
            echo <= 1'b0;
        end else if (left_r != 9'h000) begin
            left_r <= left_r - 9'h001;
        end else begin
            echo <= 1'b1;
        end
    end
endmodule

/* verif/tb_top.sv */
// self-checking bench for the phy port control register slice
`timescale 1ns/10ps
module tb_top;
    localparam int         SYM_W    = 5;
    localparam logic [7:0] P1_DIAG  = {ppc_pkg::IDX_P1_DIAG, 2'b00};
    localparam logic [7:0] P1_FAULT = {ppc_pkg::IDX_P1_FAULT, 2'b00};
    localparam logic [7:0] P1_LINK  = {ppc_pkg::IDX_P1_LINK, 2'b00};
    localparam logic [7:0] P2_DIAG  = {ppc_pkg::IDX_P2_DIAG, 2'b00};
    localparam logic [7:0] P2_FAULT = {ppc_pkg::IDX_P2_FAULT, 2'b00};
    localparam logic [7:0] P2_LINK  = {ppc_pkg::IDX_P2_LINK, 2'b00};
    typedef struct { logic [7:0] a; logic [7:0] wd; logic [7:0] rd; logic er; } ppc_row_t;

    logic                  mclk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [7:0]            paddr = 8'h00;
    logic [31:0]           pwdata = 32'h0000_0000;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic [1:0]            an_fail = 2'h0;
    logic                  arm1 = 1'b0;
    logic                  arm2 = 1'b0;
    logic [8:0]            dly = 9'h014;
    logic                  echo1;
    logic                  echo2;
    logic [SYM_W-1:0]      rx1, rx2, tx1, tx2, mrx1, mrx2, s;
    logic [SYM_W-1:0]      mac1 = '0;
    ppc_pkg::ppc_phy_ctl_t ctl1, ctl2;
    logic [31:0]           d;
    logic                  e;
    int                    failures = 0;
    int                    samples_checked = 0;
    ppc_row_t              rows[8] = '{
        '{P1_LINK, 8'hFF, 8'hE0, 1'b0}, '{P1_LINK, 8'h00, 8'h00, 1'b0},
        '{P2_LINK, 8'h40, 8'h40, 1'b0}, '{P1_DIAG, 8'h0D, 8'h08, 1'b0},
        '{P2_DIAG, 8'h06, 8'h02, 1'b0}, '{P2_FAULT, 8'hFF, 8'h00, 1'b0},
        '{8'h74, 8'h55, 8'h00, 1'b1}, '{8'h69, 8'h55, 8'h00, 1'b1}};

    initial begin
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        mac1 <= mac1 + SYM_W'(3);
    end

    ppc_regs DUT (
        .mclk, .sys_rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .port1_strap_a(1'b0), .port1_strap_b(1'b1), .port2_strap_a(1'b1),
        .port2_strap_b(1'b0), .port1_echo(echo1), .port2_echo(echo2), .autoneg_failed(an_fail),
        .port1_rx_pair(rx1), .port2_rx_pair(rx2), .port1_mac_tx(mac1), .port2_mac_tx(~mac1),
        .port1_tx_pair(tx1), .port2_tx_pair(tx2), .port1_mac_rx(mrx1), .port2_mac_rx(mrx2),
        .port1_phy_ctl(ctl1), .port2_phy_ctl(ctl2)
    );
    ppc_cable_model #(.SYM_W(SYM_W)) u_far1 (.mclk, .arm(arm1), .dly, .echo(echo1), .rx_sym(rx1));
    ppc_cable_model #(.SYM_W(SYM_W)) u_far2 (.mclk, .arm(arm2), .dly, .echo(echo2), .rx_sym(rx2));

    // ==========================================================
    // tasks
    task automatic test_done();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        int n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            test_done();
        end
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        check(d, 32'(exp), "read");
        check(32'(e), 32'h0, "refused");
    endtask

    task automatic poll(input logic [7:0] a);
        int n = 0;
        do begin
            apb(1'b0, a, 8'h00);
            n++;
        end while (d[4] !== 1'b0 && n < 400);
        if (d[4] !== 1'b0) begin
            failures++;
            test_done();
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(P1_LINK, 8'h60);
        rd(P2_LINK, 8'hA0);
        rd(P1_FAULT, 8'h00);
        rd(P1_DIAG, 8'h00);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].wd);
            apb(1'b0, rows[i].a, 8'h00);
            check(d, 32'(rows[i].rd), "row");
            check(32'(e), 32'(rows[i].er), "row err");
        end
        repeat (2) @(posedge mclk);
        check(ctl1, 6'b000110, "ctl1");
        check(ctl2, 6'b010101, "ctl2");
        @(negedge mclk);
        s = rx2;
        @(negedge mclk);
        check(tx2, s, "loop2");
        check(mrx2, s, "rx2");
        s = mac1;
        @(negedge mclk);
        check(tx1, s, "tx1");
        apb(1'b1, P1_LINK, 8'h80);
        an_fail <= 2'h1;
        repeat (3) @(posedge mclk);
        check(ctl1.use_forced, 1'b1, "forced");
        an_fail <= 2'h0;
        repeat (3) @(posedge mclk);
        check(ctl1.use_forced, 1'b0, "an");
        apb(1'b1, P1_DIAG, 8'h18);
        rd(P1_DIAG, 8'h18);
        poll(P1_DIAG);
        rd(P1_DIAG, 8'h09);
        rd(P1_FAULT, 8'hFF);
        apb(1'b1, P1_DIAG, 8'h0E);
        rd(P1_DIAG, 8'h0B);
        rd(P1_FAULT, 8'hFF);
        apb(1'b1, P2_DIAG, 8'h12);
        arm2 <= 1'b1;
        poll(P2_DIAG);
        arm2 <= 1'b0;
        rd(P2_DIAG, 8'h02);
        apb(1'b0, P2_FAULT, 8'h00);
        check(32'(d[7:0] >= 8'h10 && d[7:0] <= 8'h20), 32'h1, "fault");
        test_done();
    end
endmodule
